// ==== rtl/arr_top.sv ====
// Measurement result register bank with its serial target port and alarm 1.
// Assumes the conversion engine shares i_clk and hands over one result
// per i_meas_valid pulse; the serial pins are open drain and pulled up.
`timescale 1ns/1ps
`include "arr_defs.svh"

module arr_top
    import arr_pkg::*;
(
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // Serial pins
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda_out,
    output logic             o_sda_oe,
    // Conversion engine
    input  wire logic        i_meas_valid,
    input  wire logic [2:0]  i_meas_chan,
    input  wire logic [15:0] i_meas_data,
    input  wire logic        i_conv_done,
    output logic             o_conv_trigger,
    output logic [1:0]       o_read_rate,
    output logic [1:0]       o_conv_speed,
    // Alarm 1
    output logic             o_alarm1
);
    arr_pin_if pin ();

    arr_state_e state_r, state_nxt;
    logic [3:0] bitcnt_r, bitcnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic       rw_r, rw_nxt;
    logic       oe_r, oe_nxt;
    logic       sda_out_r;
    logic       wr_en;
    logic       rd_load;
    logic [7:0] rd_byte;
    logic [3:0] rd_slot;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] thr_hi_r, thr_hi_nxt;
    logic [7:0] thr_lo_r, thr_lo_nxt;
    logic       alarm_r, alarm_nxt;
    arr_word_t  thr_word;
    arr_word_t  result_mem [0:7];

    // Pin synchronisers and event detection
    arr_pin_sync u_pin_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_scl   (i_scl),
        .i_sda   (i_sda),
        .pins    (pin)
    );

    // Maps a location to {valid, channel} for the result pairs
    function automatic logic [3:0] result_slot(input logic [7:0] a);
        case (a)
            `ARR_REG_TS_M, `ARR_REG_TS_L:     result_slot = {1'b1, `ARR_CH_TS};   // see [RULE_01] see [RULE_09]
            `ARR_REG_CHARGE_CURRENT_CHANNEL_M, `ARR_REG_CHARGE_CURRENT_CHANNEL_L: result_slot = {1'b1, `ARR_CH_CHARGE_CURRENT_CHANNEL}; // see [RULE_02]
            `ARR_REG_AUX_M, `ARR_REG_AUX_L:   result_slot = {1'b1, `ARR_CH_AUX};  // see [RULE_03]
            `ARR_REG_VIN_M, `ARR_REG_VIN_L:   result_slot = {1'b1, `ARR_CH_VIN};  // see [RULE_04]
            `ARR_REG_SYS_M, `ARR_REG_SYS_L:   result_slot = {1'b1, `ARR_CH_SYS};  // see [RULE_05]
            `ARR_REG_IIN_M, `ARR_REG_IIN_L:   result_slot = {1'b1, `ARR_CH_IIN};  // see [RULE_06]
            default:                          result_slot = 4'h0;
        endcase
    endfunction : result_slot

    // Read data for the current location; even holds high byte, odd low byte
    function automatic logic [7:0] read_byte(input logic [7:0] a, input arr_word_t w);
        logic [3:0] s;
        s = result_slot(a);
        if (s[3]) begin
            read_byte = a[`ARR_LANE_BIT] ? w[7:0] : w[15:8]; // see [RULE_12]
        end else begin
            case (a)
                `ARR_REG_CTRL:   read_byte = ctrl_r;
                `ARR_REG_THR1_H: read_byte = thr_hi_r;
                `ARR_REG_THR1_L: read_byte = thr_lo_r;
                default:         read_byte = 8'h00;
            endcase
        end
    endfunction : read_byte

    // Slot under the pointer; only its channel bits index the store
    always_comb begin
        rd_slot = result_slot(ptr_r);
        rd_byte = read_byte(ptr_r, result_mem[rd_slot[2:0]]);
    end

    // Serial sequencer: address, pointer, then write or read bytes
    always_comb begin
        state_nxt  = state_r;
        bitcnt_nxt = bitcnt_r;
        shift_nxt  = shift_r;
        ptr_nxt    = ptr_r;
        rw_nxt     = rw_r;
        oe_nxt     = oe_r;
        wr_en      = 1'b0;
        rd_load    = 1'b0;
        if (pin.stop) begin
            state_nxt = ARR_IDLE;
            oe_nxt    = 1'b0;
        end else if (pin.start) begin
            state_nxt  = ARR_ADDR;
            bitcnt_nxt = 4'h0;
            oe_nxt     = 1'b0;
        end else if (pin.scl_rise) begin
            case (state_r)
                ARR_ADDR, ARR_PTR, ARR_WDATA: begin
                    shift_nxt  = {shift_r[6:0], pin.sda};
                    bitcnt_nxt = bitcnt_r + 4'h1;
                end
                ARR_RACK: state_nxt = pin.sda ? ARR_IDLE : ARR_RLOAD; // Not-acknowledge ends the read
                default: ;
            endcase
        end else if (pin.scl_fall) begin
            case (state_r)
                ARR_ADDR: begin
                    if (bitcnt_r == `ARR_RX_LAST) begin
                        if (shift_r[7:1] == `ARR_TARGET_ADDR) begin
                            rw_nxt    = shift_r[0];
                            oe_nxt    = 1'b1;
                            state_nxt = ARR_AACK;
                        end else begin
                            state_nxt = ARR_IDLE;
                        end
                    end
                end
                ARR_PTR: begin
                    if (bitcnt_r == `ARR_RX_LAST) begin
                        ptr_nxt   = shift_r;
                        oe_nxt    = 1'b1;
                        state_nxt = ARR_DACK;
                    end
                end
                ARR_WDATA: begin
                    if (bitcnt_r == `ARR_RX_LAST) begin
                        wr_en     = 1'b1;
                        ptr_nxt   = ptr_r + 8'h01;
                        oe_nxt    = 1'b1;
                        state_nxt = ARR_DACK;
                    end
                end
                ARR_AACK: begin
                    if (rw_r) begin
                        rd_load = 1'b1;
                    end else begin
                        oe_nxt     = 1'b0;
                        bitcnt_nxt = 4'h0;
                        state_nxt  = ARR_PTR;
                    end
                end
                ARR_DACK: begin
                    oe_nxt     = 1'b0;
                    bitcnt_nxt = 4'h0;
                    state_nxt  = ARR_WDATA;
                end
                ARR_RLOAD: rd_load = 1'b1;
                ARR_RDATA: begin
                    if (bitcnt_r == `ARR_TX_LAST) begin
                        oe_nxt    = 1'b0;
                        state_nxt = ARR_RACK;
                    end else begin
                        shift_nxt  = {shift_r[6:0], 1'b0};
                        oe_nxt     = ~shift_r[6]; // Pull low for a zero bit
                        bitcnt_nxt = bitcnt_r + 4'h1;
                    end
                end
                default: ;
            endcase
            if (rd_load) begin
                shift_nxt  = rd_byte;
                ptr_nxt    = ptr_r + 8'h01;
                oe_nxt     = ~rd_byte[7];
                bitcnt_nxt = 4'h0;
                state_nxt  = ARR_RDATA;
            end
        end
    end

    // Sequencer registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r   <= ARR_IDLE;
            bitcnt_r  <= 4'h0;
            shift_r   <= 8'h00;
            ptr_r     <= 8'h00;
            rw_r      <= 1'b0;
            oe_r      <= 1'b0;
            sda_out_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            bitcnt_r  <= bitcnt_nxt;
            shift_r   <= shift_nxt;
            ptr_r     <= ptr_nxt;
            rw_r      <= rw_nxt;
            oe_r      <= oe_nxt;
            sda_out_r <= 1'b0;
        end
    end

    assign thr_word = {thr_hi_r, thr_lo_r[`ARR_THR_NIBBLE], 4'h0};

    // Writable registers, trigger clear and alarm compare
    always_comb begin
        ctrl_nxt   = ctrl_r;
        thr_hi_nxt = thr_hi_r;
        thr_lo_nxt = thr_lo_r;
        alarm_nxt  = alarm_r;
        if (i_conv_done) begin
            ctrl_nxt[`ARR_CTRL_TRIG] = 1'b0; // see [RULE_11]
        end
        if (wr_en) begin
            case (ptr_r)
                `ARR_REG_CTRL:   ctrl_nxt   = shift_r; // A new trigger wins over a clear
                `ARR_REG_THR1_H: thr_hi_nxt = shift_r; // see [RULE_07]
                `ARR_REG_THR1_L: thr_lo_nxt = shift_r; // see [RULE_10]
                default: ;                             // see [RULE_13]
            endcase
        end
        if (i_meas_valid && i_meas_chan == ctrl_r[`ARR_CTRL_SEL] && ctrl_r[`ARR_CTRL_SEL] != `ARR_CH_OFF) begin
            alarm_nxt = thr_lo_r[`ARR_THR_POL] ? (i_meas_data > thr_word)
                                               : (i_meas_data < thr_word); // see [RULE_10]
        end
    end

    // Register file with documented reset values
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_r   <= `ARR_CTRL_RESET;
            thr_hi_r <= `ARR_THR1_H_RESET; // see [RULE_07]
            thr_lo_r <= `ARR_THR1_L_RESET;
            alarm_r  <= 1'b0;
        end else begin
            ctrl_r   <= ctrl_nxt;
            thr_hi_r <= thr_hi_nxt;
            thr_lo_r <= thr_lo_nxt;
            alarm_r  <= alarm_nxt;
        end
    end

    // Result store: only the conversion engine writes it, never reset
    always_ff @(posedge i_clk) begin
        if (i_meas_valid) begin
            result_mem[i_meas_chan] <= i_meas_data; // see [RULE_08] see [RULE_13]
        end
    end

    // Outputs straight from flip-flops
    assign o_sda_out      = sda_out_r;
    assign o_sda_oe       = oe_r;
    assign o_conv_trigger = ctrl_r[`ARR_CTRL_TRIG];
    assign o_read_rate    = ctrl_r[`ARR_CTRL_RATE];
    assign o_conv_speed   = ctrl_r[`ARR_CTRL_SPEED];
    assign o_alarm1       = alarm_r;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_load(logic [7:0] a);
        rd_load && ptr_r == a;
    endsequence

    a_ts_low_read: assert property (s_load(`ARR_REG_TS_L) |=> shift_r == $past(result_mem[`ARR_CH_TS][7:0])) // see [RULE_01]
        else $error("thermistor low byte misread");
    a_charge_current_channel_pair: assert property (s_load(`ARR_REG_CHARGE_CURRENT_CHANNEL_M) |=> shift_r == $past(result_mem[`ARR_CH_CHARGE_CURRENT_CHANNEL][15:8])) // see [RULE_02]
        else $error("charge current high byte misread");
    a_aux_pair: assert property (s_load(`ARR_REG_AUX_L) |=> shift_r == $past(result_mem[`ARR_CH_AUX][7:0])) // see [RULE_03]
        else $error("aux input low byte misread");
    a_vin_pair: assert property (s_load(`ARR_REG_VIN_M) |=> shift_r == $past(result_mem[`ARR_CH_VIN][15:8])) // see [RULE_04]
        else $error("input voltage high byte misread");
    a_sys_pair: assert property (s_load(`ARR_REG_SYS_L) |=> shift_r == $past(result_mem[`ARR_CH_SYS][7:0])) // see [RULE_05]
        else $error("system rail low byte misread");
    a_iin_pair: assert property (s_load(`ARR_REG_IIN_M) |=> shift_r == $past(result_mem[`ARR_CH_IIN][15:8])) // see [RULE_06]
        else $error("input current high byte misread");
    a_thr_write: assert property (wr_en && ptr_r == `ARR_REG_THR1_H |=> thr_hi_r == $past(shift_r)) // see [RULE_07]
        else $error("threshold high byte not written");
    a_ts_high_read: assert property (s_load(`ARR_REG_TS_M) |=> shift_r == $past(result_mem[`ARR_CH_TS][15:8])) // see [RULE_09]
        else $error("thermistor high byte misread");
    a_alarm_above: assert property (i_meas_valid && i_meas_chan == ctrl_r[`ARR_CTRL_SEL] && i_meas_chan != `ARR_CH_OFF
        && thr_lo_r[`ARR_THR_POL] |=> o_alarm1 == ($past(i_meas_data) > $past(thr_word))) // see [RULE_10]
        else $error("alarm polarity wrong");
    a_trig_clear: assert property (i_conv_done && !(wr_en && ptr_r == `ARR_REG_CTRL) |=> !o_conv_trigger) // see [RULE_11]
        else $error("trigger not cleared");
    a_ro_ignore: assert property (wr_en && ptr_r == `ARR_REG_IIN_M && !i_meas_valid
        |=> result_mem[`ARR_CH_IIN] == $past(result_mem[`ARR_CH_IIN])) // see [RULE_13]
        else $error("result changed by host write");

endmodule : arr_top

// ==== rtl/arr_defs.svh ====
// Constants for the measurement result register bank and its serial port.
// Assumes inclusion by arr_pkg.sv and arr_top.sv; definitions only.
//
// Summary of operation
// [RULE_01] Thermistor result low byte readable at 0x45
// [RULE_02] Charge current result pair at 0x46/0x47
// [RULE_03] Aux input result pair at 0x48/0x49
// [RULE_04] Input voltage result pair at 0x4a/0x4b
// [RULE_05] System rail result pair at 0x4c/0x4d
// [RULE_06] Input current result pair at 0x4e/0x4f
// [RULE_07] Alarm 1 threshold high byte, writable, resets 0x23
// [RULE_08] Result registers carry no reset value
// [RULE_09] Thermistor result high byte readable at 0x44
// [RULE_10] 0x53 holds threshold nibble and alarm polarity
// [RULE_11] Conversion trigger clears itself when conversion completes
// [RULE_12] Result equals high byte times 256 plus low
// [RULE_13] Writes to result registers are ignored
`ifndef ARR_DEFS_SVH
`define ARR_DEFS_SVH

// Serial target address, arbitrary value
`define ARR_TARGET_ADDR   7'h2a

// Register locations
`define ARR_REG_CTRL      8'h40
`define ARR_REG_TS_M      8'h44
`define ARR_REG_TS_L      8'h45
`define ARR_REG_CHARGE_CURRENT_CHANNEL_M    8'h46
`define ARR_REG_CHARGE_CURRENT_CHANNEL_L    8'h47
`define ARR_REG_AUX_M     8'h48
`define ARR_REG_AUX_L     8'h49
`define ARR_REG_VIN_M     8'h4a
`define ARR_REG_VIN_L     8'h4b
`define ARR_REG_SYS_M     8'h4c
`define ARR_REG_SYS_L     8'h4d
`define ARR_REG_IIN_M     8'h4e
`define ARR_REG_IIN_L     8'h4f
`define ARR_REG_THR1_H    8'h52
`define ARR_REG_THR1_L    8'h53

// Reset values
`define ARR_CTRL_RESET    8'h02
`define ARR_THR1_H_RESET  8'h23
`define ARR_THR1_L_RESET  8'h20

// Field positions
`define ARR_CTRL_TRIG     5
`define ARR_CTRL_RATE     7:6
`define ARR_CTRL_SPEED    4:3
`define ARR_CTRL_SEL      2:0
`define ARR_THR_NIBBLE    7:4
`define ARR_THR_POL       3
`define ARR_LANE_BIT      0

// Channel codes
`define ARR_CH_OFF        3'h0
`define ARR_CH_AUX        3'h1
`define ARR_CH_TS         3'h2
`define ARR_CH_CHARGE_CURRENT_CHANNEL       3'h4
`define ARR_CH_VIN        3'h5
`define ARR_CH_SYS        3'h6
`define ARR_CH_IIN        3'h7

// Bit counts of a serial byte
`define ARR_RX_LAST       4'h8
`define ARR_TX_LAST       4'h7

`endif

// ==== rtl/arr_pkg.sv ====
// Types shared by the result register bank.
// Assumes arr_defs.svh is on the include path.
`include "arr_defs.svh"

package arr_pkg;

    // Serial port sequencer states
    typedef enum logic [3:0] {
        ARR_IDLE,
        ARR_ADDR,
        ARR_AACK,
        ARR_PTR,
        ARR_DACK,
        ARR_WDATA,
        ARR_RLOAD,
        ARR_RDATA,
        ARR_RACK
    } arr_state_e;

    typedef logic [15:0] arr_word_t;

endpackage : arr_pkg

// ==== rtl/arr_pin_if.sv ====
// Synchronised serial pin events passed from the pin stage to the bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface arr_pin_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;

    modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
    modport dst (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : arr_pin_if

// ==== rtl/arr_pin_sync.sv ====
// Two-flop synchronisers and edge / start / stop detection for the serial pins.
// Assumes the pins are asynchronous to i_clk and change slowly against it.
`timescale 1ns/1ps

module arr_pin_sync (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset,
    // Serial pins
    input  wire logic i_scl,
    input  wire logic i_sda,
    // Events
    arr_pin_if.src    pins
);
    logic [1:0] meta_r, meta_nxt;
    logic [1:0] sync_r, sync_nxt;
    logic [1:0] prev_r, prev_nxt;

    // Next values of the three stages; index 1 is clock, 0 is data
    always_comb begin
        meta_nxt = {i_scl, i_sda};
        sync_nxt = meta_r;
        prev_nxt = sync_r;
    end

    // Stage registers, idle-high after reset
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_r <= 2'h3;
            sync_r <= 2'h3;
            prev_r <= 2'h3;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            prev_r <= prev_nxt;
        end
    end

    // Events read only the second and third stages
    assign pins.scl_rise = sync_r[1] & ~prev_r[1];
    assign pins.scl_fall = ~sync_r[1] & prev_r[1];
    assign pins.start    = sync_r[1] & prev_r[1] & prev_r[0] & ~sync_r[0];
    assign pins.stop     = sync_r[1] & prev_r[1] & ~prev_r[0] & sync_r[0];
    assign pins.sda      = sync_r[0];

endmodule : arr_pin_sync

// ==== dv/arr_host_model.sv ====
// Serial host model: open-drain controller that writes and reads registers.
// Assumes the wire level is resolved outside, with pull-up, and fed to i_sda.
`timescale 1ns/1ps
`include "arr_defs.svh"

module arr_host_model (
    // Clock
    input  wire logic       i_clk,
    // Resolved data wire
    input  wire logic       i_sda,
    // Pin drive
    output logic            o_scl,
    output logic            o_sda_low,
    // Byte read back
    output logic            o_rd_valid,
    output logic [7:0]      o_rd_data
);
    int nak_count = 0;

    // Idle bus: clock high, data released
    initial begin
        o_scl      = 1'b1;
        o_sda_low  = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_data  = 8'h00;
    end

    // Wait falling edges of the system clock
    task automatic gap(input int n);
        repeat (n) @(negedge i_clk);
    endtask : gap

    // One bit slot, each phase 10 cycles so the synchronisers keep up
    task automatic bit_slot(input logic b, output logic r);
        o_sda_low = !b;
        gap(10);
        o_scl = 1'b1;
        gap(5);
        r = i_sda;
        gap(5);
        o_scl = 1'b0;
        gap(1);
    endtask : bit_slot

    // Start or repeated start
    task automatic start_cond;
        o_sda_low = 1'b0;
        gap(10);
        o_scl = 1'b1;
        gap(10);
        o_sda_low = 1'b1;
        gap(10);
        o_scl = 1'b0;
        gap(1);
    endtask : start_cond

    // Stop, bus left idle
    task automatic stop_cond;
        o_sda_low = 1'b1;
        gap(10);
        o_scl = 1'b1;
        gap(10);
        o_sda_low = 1'b0;
        gap(10);
    endtask : stop_cond

    // Byte out MSB first, then count a missing acknowledge
    task automatic send_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
        bit_slot(1'b1, r);
        if (r !== 1'b0) nak_count++;
    endtask : send_byte

    // Byte in MSB first; the last one is refused to end the read
    task automatic get_byte(input logic last);
        logic [7:0] v;
        logic       r;
        for (int i = 7; i >= 0; i--) bit_slot(1'b1, v[i]);
        bit_slot(last, r);
        o_rd_data  = v;
        o_rd_valid = 1'b1;
        gap(1);
        o_rd_valid = 1'b0;
    endtask : get_byte

    // Address phase only, for a target that must stay silent
    task automatic probe(input logic [6:0] a);
        start_cond();
        send_byte({a, 1'b0});
        stop_cond();
    endtask : probe

    // Single register write
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
        start_cond();
        send_byte({`ARR_TARGET_ADDR, 1'b0});
        send_byte(ptr);
        send_byte(d);
        stop_cond();
    endtask : wr

    // Pointer set, repeated start, then n bytes in one transfer
    task automatic rd(input logic [7:0] ptr, input int n);
        start_cond();
        send_byte({`ARR_TARGET_ADDR, 1'b0});
        send_byte(ptr);
        start_cond();
        send_byte({`ARR_TARGET_ADDR, 1'b1});
        for (int k = 0; k < n; k++) get_byte(k == n - 1); // All n bytes read in one transfer
        stop_cond();
    endtask : rd
endmodule : arr_host_model

// ==== dv/adc_result_readout_regs_bench.sv ====
// Self-checking bench for the result register bank behind its serial port.
// Assumes the host model in arr_host_model.sv and the bank in arr_top.sv.
`timescale 1ns/1ps

module adc_result_readout_regs_bench;
    logic        clk;
    logic        reset;
    logic        meas_valid;
    logic [2:0]  meas_chan;
    logic [15:0] meas_data;
    logic        conv_done;
    logic        scl;
    logic        host_low;
    logic        sda_out;
    logic        sda_oe;
    logic        rd_valid;
    logic [7:0]  rd_data;
    logic        conv_trig;
    logic        alarm1;
    logic [1:0]  read_rate;
    logic [1:0]  conv_speed;
    logic [7:0]  exp_q[$];
    int          fail_count = 0;
    int          n_compared = 0;
    logic [2:0]  chans[6]   = '{3'h2, 3'h4, 3'h1, 3'h5, 3'h6, 3'h7};
    logic [7:0]  addrs[6]   = '{8'h44, 8'h46, 8'h48, 8'h4a, 8'h4c, 8'h4e};
    // Open-drain wire with pull-up
    wire         sda_wire   = (sda_oe || host_low) ? 1'b0 : 1'b1;

    // 100 MHz clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    arr_top arr_top_inst (
        .i_clk(clk), .i_reset(reset), .i_scl(scl), .i_sda(sda_wire),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_meas_valid(meas_valid),
        .i_meas_chan(meas_chan), .i_meas_data(meas_data), .i_conv_done(conv_done),
        .o_conv_trigger(conv_trig), .o_read_rate(read_rate), .o_conv_speed(conv_speed),
        .o_alarm1(alarm1)
    );

    arr_host_model arr_host_model_inst (
        .i_clk(clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(host_low),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data)
    );

    // Verdict and end of run
    task automatic summarize;
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // Compare and count
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // One result from the conversion engine
    task automatic meas(input logic [2:0] ch, input logic [15:0] d);
        @(negedge clk);
        meas_valid = 1'b1;
        meas_chan  = ch;
        meas_data  = d;
        @(negedge clk);
        meas_valid = 1'b0;
        @(negedge clk);
    endtask : meas

    // Each byte read back is matched with the oldest expectation
    always @(posedge rd_valid) begin
        if (exp_q.size() == 0) begin
            fail_count++;
            $display("MISMATCH read_byte expected none seen %h", rd_data);
        end else begin
            check("read_byte", {8'h00, exp_q.pop_front()}, {8'h00, rd_data});
            check("sda_out", 16'h0000, {15'h0, sda_out});
        end
    end

    // Hang guard
    initial begin
        repeat (100000) @(negedge clk);
        fail_count++;
        $display("MISMATCH run_length expected done seen timeout");
        summarize();
    end

    // Main sequence
    initial begin
        logic [15:0] v;
        logic [7:0]  b;
        reset      = 1'b1;
        meas_valid = 1'b0;
        meas_chan  = 3'h0;
        meas_data  = 16'h0000;
        conv_done  = 1'b0;
        void'($urandom(88212));
        repeat (20) @(negedge clk);
        reset = 1'b0;
        repeat (5) @(negedge clk);
        // Threshold pair after reset
        exp_q.push_back(8'h23);
        exp_q.push_back(8'h20);
        arr_host_model_inst.rd(8'h52, 2);
        // Every channel stored and read back high then low
        for (int k = 0; k < 6; k++) begin
            v = 16'($urandom());
            meas(chans[k], v);
            exp_q.push_back(v[15:8]);
            exp_q.push_back(v[7:0]);
            arr_host_model_inst.rd(addrs[k], 2);
        end
        // Write to a result byte is ignored; next free location reads zero
        arr_host_model_inst.wr(8'h4e, ~v[15:8]);
        exp_q.push_back(v[15:8]);
        exp_q.push_back(v[7:0]);
        exp_q.push_back(8'h00);
        arr_host_model_inst.rd(8'h4e, 3);
        // Threshold written and read back, polarity above
        b = {1'b1, 7'($urandom())};
        arr_host_model_inst.wr(8'h52, b);
        arr_host_model_inst.wr(8'h53, 8'h08);
        exp_q.push_back(b);
        exp_q.push_back(8'h08);
        arr_host_model_inst.rd(8'h52, 2);
        // Alarm on thermistor channel against {b, 0x00}
        arr_host_model_inst.wr(8'h40, 8'hca);
        check("read_rate", 16'h0003, {14'h0, read_rate});
        check("conv_speed", 16'h0001, {14'h0, conv_speed});
        meas(3'h2, {b, 8'h01});
        check("alarm_above", 16'h0001, {15'h0, alarm1});
        meas(3'h2, {b - 8'h01, 8'hff});
        check("alarm_not_above", 16'h0000, {15'h0, alarm1});
        arr_host_model_inst.wr(8'h53, 8'h00);
        meas(3'h2, {b - 8'h01, 8'hff});
        check("alarm_below", 16'h0001, {15'h0, alarm1});
        meas(3'h4, 16'hffff);
        check("alarm_other_chan", 16'h0001, {15'h0, alarm1});
        // Trigger set by host, cleared by completion
        arr_host_model_inst.wr(8'h40, 8'h2a);
        check("trigger_set", 16'h0001, {15'h0, conv_trig});
        conv_done = 1'b1;
        @(negedge clk);
        conv_done = 1'b0;
        @(negedge clk);
        check("trigger_clear", 16'h0000, {15'h0, conv_trig});
        exp_q.push_back(8'h0a);
        arr_host_model_inst.rd(8'h40, 1);
        // Foreign target address gets no acknowledge
        arr_host_model_inst.probe(7'h2b);
        check("address_nak", 16'h0001, 16'(arr_host_model_inst.nak_count));
        for (int t = 0; t < 100 && exp_q.size() != 0; t++) @(negedge clk);
        if (exp_q.size() != 0) begin
            fail_count++;
            $display("MISMATCH read_queue expected 0 seen %0d", exp_q.size());
        end
        summarize();
    end
endmodule : adc_result_readout_regs_bench
